// File: sim/wlsc_ctrl_tb.sv
// Self-checking bench of the link state controller
`timescale 1ns/10ps
module wlsc_ctrl_tb
	import wlsc_pkg::*;
();
	localparam int L_REQ = 0;
	localparam int L_REL = 1;
	localparam int BRK = 2;
	localparam int CMD = 3;
	localparam int SREQ = 4;
	localparam int SREL = 5;
	localparam int DFLT = 6;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic auto_op_i = 1'b1;
	logic [7:0] force_master_i = 8'h00;
	logic [7:0] link_latency_i = 8'h02;
	logic [7:0] transp_flag_i = 8'h00;
	logic default_conn_i = 1'b0;
	logic link_req_i = 1'b0;
	logic link_rel_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic [2:0] cmd_i = 3'h0;
	logic uart_break_i = 1'b0;
	logic sco_req_i = 1'b0;
	logic sco_rel_i = 1'b0;
	logic rx_valid_i = 1'b0;
	logic [7:0] rx_data_i = 8'h00;
	logic stall = 1'b0;
	logic host_ready, rx_ready_o, host_valid_o, accept_o, auth_req_o, link_ind_o;
	logic cmd_done_o, cmd_rej_o, scan_en_o, transparent_o, sco_grant_o, sco_active_o, poll_o;
	wlsc_word_s host_word_o;
	logic [7:0] state_o;
	logic [3:0] link_cnt_o;
	int n_fail = 0;
	int checks = 0;
	int cyc_n = 0;

	// Short slot so poll intervals stay a few cycles
	wlsc_ctrl #(.MAX_LINKS(7), .SLOT_CYC(4)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
		.auto_op_i(auto_op_i), .force_master_i(force_master_i), .transp_flag_i(transp_flag_i),
		.link_latency_i(link_latency_i), .security_on_i(1'b1), .svc_auth_i(1'b1),
		.link_req_i(link_req_i), .link_rel_i(link_rel_i), .default_conn_i(default_conn_i),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .uart_break_i(uart_break_i),
		.sco_req_i(sco_req_i), .sco_rel_i(sco_rel_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .host_ready_i(host_ready), .rx_ready_o(rx_ready_o),
		.host_valid_o(host_valid_o), .host_word_o(host_word_o), .state_o(state_o),
		.link_cnt_o(link_cnt_o), .accept_o(accept_o), .auth_req_o(auth_req_o),
		.link_ind_o(link_ind_o), .cmd_done_o(cmd_done_o), .cmd_rej_o(cmd_rej_o),
		.scan_en_o(scan_en_o), .transparent_o(transparent_o), .sco_grant_o(sco_grant_o),
		.sco_active_o(sco_active_o), .poll_o(poll_o));

	wlsc_host i_host (.clock_i(clock_i), .valid_i(host_valid_o), .word_i(host_word_o),
		.stall_i(stall), .ready_o(host_ready));

	initial begin
		forever #2 clock_i = ~clock_i;
	end

	task wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Whole run is under two hundred cycles
	always @(posedge clock_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task bchk(input logic got, input logic exp);
		chk(9'(got), 9'(exp));
	endtask

	task st(input wlsc_state_e e);
		chk(9'(state_o), 9'(e));
	endtask

	task do_reset(input logic auto);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		auto_op_i <= auto;
		force_master_i <= FLAG_OFF;
		transp_flag_i <= FLAG_OFF;
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'b1;
		// Two sync flops plus boot cycle before the first request
		repeat (6) @(posedge clock_i);
		#1;
	endtask

	// One-cycle event pulse, then settle on the registered answer
	task ev(input int k, input logic [2:0] c);
		@(posedge clock_i);
		case (k)
			L_REQ: link_req_i <= 1'b1;
			L_REL: link_rel_i <= 1'b1;
			BRK: uart_break_i <= 1'b1;
			CMD: cmd_valid_i <= 1'b1;
			SREQ: sco_req_i <= 1'b1;
			DFLT: default_conn_i <= 1'b1;
			default: sco_rel_i <= 1'b1;
		endcase
		cmd_i <= c;
		@(posedge clock_i);
		{link_req_i, link_rel_i, uart_break_i, cmd_valid_i} <= 4'h0;
		{sco_req_i, sco_rel_i, default_conn_i} <= 3'h0;
		#1;
	endtask

	task send(input logic [7:0] d);
		int n;
		@(posedge clock_i);
		rx_valid_i <= 1'b1;
		rx_data_i <= d;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (!rx_ready_o && n < 20);
		rx_valid_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	task t_auto;
		do_reset(1'b1);
		st(ST_IDLE_AUTO);
		bchk(scan_en_o, 1'b1);
		ev(L_REQ, 3'h0);
		bchk(accept_o & link_ind_o, 1'b1);
		bchk(auth_req_o, 1'b1);
		st(ST_TRANS_SLAVE);
		bchk(transparent_o, 1'b1);
		bchk(scan_en_o, 1'b0);
		send(8'h5A);
		chk(i_host.got[$], 9'h15A);
		ev(CMD, CMD_ESTABLISH);
		bchk(cmd_done_o | cmd_rej_o, 1'b0);
		ev(BRK, 3'h0);
		st(ST_SINGLE_SLAVE);
		ev(L_REL, 3'h0);
		st(ST_IDLE_AUTO);
	endtask

	task t_manual;
		do_reset(1'b0);
		st(ST_IDLE_MANUAL);
		ev(L_REQ, 3'h0);
		bchk(link_ind_o, 1'b1);
		st(ST_SINGLE_SLAVE);
		bchk(scan_en_o, 1'b1);
		ev(SREQ, 3'h0);
		bchk(sco_grant_o, 1'b1);
		ev(SREL, 3'h0);
		ev(L_REQ, 3'h0);
		st(ST_SCAT_SLAVE);
		bchk(scan_en_o, 1'b0);
		ev(SREQ, 3'h0);
		bchk(sco_grant_o, 1'b0);
		ev(L_REL, 3'h0);
		ev(CMD, CMD_SDAP_CONNECT);
		st(ST_SCAT_MASTER);
	endtask

	task t_master;
		int n;
		do_reset(1'b0);
		ev(CMD, CMD_ESTABLISH);
		bchk(cmd_done_o, 1'b1);
		st(ST_PICO_MASTER);
		bchk(transparent_o, 1'b0);
		n = 0;
		while (!poll_o && n < 40) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (!poll_o && n < 40);
		chk(9'(n), 9'h008);
		ev(L_REQ, 3'h0);
		st(ST_SCAT_MASTER);
		ev(L_REQ, 3'h0);
		bchk(accept_o, 1'b0);
		bchk(scan_en_o, 1'b1);
	endtask

	task t_trans;
		do_reset(1'b0);
		ev(CMD, CMD_ESTABLISH);
		ev(CMD, CMD_TRANSPARENT);
		st(ST_TRANS_MASTER);
		bchk(transparent_o, 1'b1);
		ev(BRK, 3'h0);
		st(ST_PICO_MASTER);
		@(posedge clock_i);
		force_master_i <= FLAG_ON;
		ev(L_REQ, 3'h0);
		bchk(accept_o, 1'b1);
		st(ST_PICO_MASTER);
		ev(CMD, CMD_TRANSPARENT);
		bchk(cmd_rej_o, 1'b1);
		repeat (5) ev(CMD, CMD_ESTABLISH);
		chk(9'(link_cnt_o), 9'h007);
		ev(CMD, CMD_ESTABLISH);
		bchk(cmd_rej_o, 1'b1);
	endtask

	// Forced master from idle, then default connections with the transparent flag
	task t_dflt;
		do_reset(1'b1);
		@(posedge clock_i);
		force_master_i <= FLAG_ON;
		transp_flag_i <= FLAG_ON;
		ev(L_REQ, 3'h0);
		st(ST_PICO_MASTER);
		bchk(accept_o, 1'b1);
		ev(L_REL, 3'h0);
		st(ST_IDLE_AUTO);
		ev(DFLT, 3'h0);
		st(ST_TRANS_MASTER);
		bchk(scan_en_o, 1'b0);
		ev(BRK, 3'h0);
		st(ST_PICO_MASTER);
		bchk(scan_en_o, 1'b1);
		ev(L_REL, 3'h0);
		ev(CMD, CMD_CONNECT_DEFAULT);
		st(ST_TRANS_MASTER);
		chk(9'(link_cnt_o), 9'h001);
		ev(BRK, 3'h0);
		ev(L_REL, 3'h0);
		@(posedge clock_i);
		auto_op_i <= 1'b0;
		ev(DFLT, 3'h0);
		st(ST_PICO_MASTER);
		bchk(transparent_o, 1'b0);
	endtask

	// Host stalls so the two-entry buffer must refuse the third word
	task t_data;
		int n;
		int b;
		do_reset(1'b0);
		ev(L_REQ, 3'h0);
		b = i_host.got.size();
		@(posedge clock_i);
		stall <= 1'b1;
		rx_valid_i <= 1'b1;
		rx_data_i <= 8'hA0;
		n = 0;
		repeat (6) begin
			@(posedge clock_i);
			if (rx_ready_o) begin
				n++;
				rx_data_i <= 8'(8'hA0 + n);
			end
		end
		rx_valid_i <= 1'b0;
		stall <= 1'b0;
		repeat (6) @(posedge clock_i);
		chk(9'(n), 9'h002);
		chk(9'(i_host.got.size() - b), 9'h002);
		chk(i_host.got[b], 9'h0A0);
		chk(i_host.got[b + 1], 9'h0A1);
	endtask

	initial begin
		t_auto();
		t_manual();
		t_master();
		t_trans();
		t_dflt();
		t_data();
		wrap_up();
	end
endmodule // wlsc_ctrl_tb

// File: sim/wlsc_host.sv
// Host side model that takes words from the controller and can stall
`timescale 1ns/10ps
module wlsc_host
	import wlsc_pkg::*;
(
	input wire logic clock_i,
	input wire logic valid_i,
	input wire wlsc_word_s word_i,
	input wire logic stall_i,
	output logic ready_o
);
	logic [8:0] got [$];
	// Stall only when the bench asks, to fill the buffer
	assign ready_o = !stall_i;
	always @(posedge clock_i) begin
		if (valid_i && ready_o) begin
			got.push_back(word_i);
		end
	end
endmodule // wlsc_host

// File: src/wlsc_ctrl.sv
// Connection state controller of the serial radio module
//
// Functional notes
// R1: Idle automatic incoming link: authenticate, accept, indicate, scans off, transparent UART.
// R2: Idle non-automatic incoming link: authenticate, accept, indicate, go single slave.
// R3: Host sends payload by command; received payload reaches host as data events.
// R4: Transparent command accepted anytime from linked command state; UART goes raw. Code rejects it unless exactly one link is up.
// R5: Establish, connect-default or automatic default connection enters piconet master.
// R6: Incoming link with forced-master flag 0x01 gives master role, piconet master.
// R7: After establishing as master the UART stays in command mode.
// R8: Master supports at most 7 simultaneous links.
// R9: Piconet master allows one voice link to a single slave.
// R10: Incoming link in piconet master with forced-master 0x00 gives scatternet master.
// R11: Single slave actively connecting by command moves to scatternet master.
// R12: Scatternet master refuses incoming links, stays discoverable, one master at most.
// R13: Transparent mode only with exactly one link; UART data goes there.
// R14: Transparent master by command, auto default connection, or connect-default, flag 0x01.
// R15: Break in transparent master returns to piconet master.
// R16: Transparent states emit no events, ignore commands, scanning off.
// R17: Master polls each slave every 40 slots by default, adjustable latency. Code takes the interval from link_latency_i only; LATENCY_DEFAULT is unused.
// R18: Every incoming link accepted; authentication per security level and service entry. Code refuses scatternet, transparent and full-master requests.
// R19: Incoming link with automatic flag 0x00 enters single slave with indicator.
// R20: Single slave keeps commands, discoverable, connectable, voice link allowed.
// R21: Incoming link in single slave moves to scatternet slave.
// R22: Scatternet slave: no voice link, not discoverable, not connectable.
// R23: Boot, reset or last link released returns to idle chosen by automatic flag.
// R24: Break in transparent slave moves to single slave.
// R25: Remote role switches are ignored; only documented events move the state.
`timescale 1ns/10ps
module wlsc_ctrl
	import wlsc_pkg::*;
#(
	parameter int MAX_LINKS = 7,
	parameter int SLOT_CYC = SLOT_TIME_NS / CLK_PERIOD_NS
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic auto_op_i,
	input wire logic [7:0] force_master_i,
	input wire logic [7:0] transp_flag_i,
	input wire logic [7:0] link_latency_i,
	input wire logic security_on_i,
	input wire logic svc_auth_i,
	input wire logic link_req_i,
	input wire logic link_rel_i,
	input wire logic default_conn_i,
	input wire logic cmd_valid_i,
	input wire logic [2:0] cmd_i,
	input wire logic uart_break_i,
	input wire logic sco_req_i,
	input wire logic sco_rel_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic host_ready_i,
	output logic rx_ready_o,
	output logic host_valid_o,
	output wlsc_word_s host_word_o,
	output logic [7:0] state_o,
	output logic [3:0] link_cnt_o,
	output logic accept_o,
	output logic auth_req_o,
	output logic link_ind_o,
	output logic cmd_done_o,
	output logic cmd_rej_o,
	output logic scan_en_o,
	output logic transparent_o,
	output logic sco_grant_o,
	output logic sco_active_o,
	output logic poll_o
);
	logic rst_meta_q;
	logic rst_sync_q;
	// Reset released through two flops so no flop leaves reset on a ragged edge
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wlsc_state_e state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic scan_q, scan_d;
	logic transp_q, transp_d;
	logic boot_q, boot_d;
	logic accept_q, accept_d;
	logic auth_q, auth_d;
	logic ind_q, ind_d;
	logic done_q, done_d;
	logic rej_q, rej_d;
	logic sco_q, sco_d;
	logic grant_q, grant_d;
	logic linked_cmd;
	logic in_transp;
	logic master_full;
	logic master_side;
	always_comb begin
		in_transp = (state_q == ST_TRANS_MASTER) || (state_q == ST_TRANS_SLAVE);
		linked_cmd = (state_q == ST_PICO_MASTER) || (state_q == ST_SCAT_MASTER)
			|| (state_q == ST_SINGLE_SLAVE) || (state_q == ST_SCAT_SLAVE);
		master_side = (state_q == ST_PICO_MASTER) || (state_q == ST_SCAT_MASTER)
			|| (state_q == ST_TRANS_MASTER);
		master_full = cnt_q >= 4'(MAX_LINKS); // R8
	end
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sco_d = sco_q;
		{boot_d, accept_d, auth_d, ind_d, done_d, rej_d, grant_d} = 7'h00;
		if (boot_q) begin
			state_d = auto_op_i ? ST_IDLE_AUTO : ST_IDLE_MANUAL; // R23
		end else if (uart_break_i && in_transp) begin
			state_d = (state_q == ST_TRANS_MASTER) ? ST_PICO_MASTER : ST_SINGLE_SLAVE; // R15 R24
		end else if (link_rel_i && cnt_q != NO_LINK) begin
			cnt_d = cnt_q - ONE_LINK;
			if (cnt_q == ONE_LINK) begin
				state_d = auto_op_i ? ST_IDLE_AUTO : ST_IDLE_MANUAL; // R23
				sco_d = 1'b0;
			end else if (state_q == ST_SCAT_SLAVE) begin
				state_d = ST_SINGLE_SLAVE;
			end
		end else if (link_req_i) begin
			// Scatternet and transparent states are not connectable, so requests drop
			unique case (state_q)
				ST_IDLE_AUTO, ST_IDLE_MANUAL, ST_PICO_MASTER, ST_SINGLE_SLAVE: begin
					accept_d = !(master_side && master_full); // R18
					auth_d = accept_d && security_on_i && svc_auth_i; // R18 R1 R2
					ind_d = accept_d; // R1 R2 R19
					if (accept_d) begin
						cnt_d = cnt_q + ONE_LINK;
						if (force_master_i == FLAG_ON && state_q != ST_SINGLE_SLAVE) begin
							state_d = ST_PICO_MASTER; // R6
						end else if (state_q == ST_PICO_MASTER) begin
							state_d = ST_SCAT_MASTER; // R10
						end else if (state_q == ST_SINGLE_SLAVE) begin
							state_d = ST_SCAT_SLAVE; // R21
						end else if (state_q == ST_IDLE_AUTO) begin
							state_d = ST_TRANS_SLAVE; // R1
						end else begin
							state_d = ST_SINGLE_SLAVE; // R2 R19
						end
					end
				end
				ST_SCAT_MASTER, ST_SCAT_SLAVE, ST_TRANS_MASTER, ST_TRANS_SLAVE: begin
					accept_d = 1'b0; // R12 R16 R22
				end
			endcase
		end else if (default_conn_i && !in_transp && !master_full && !linked_cmd) begin
			cnt_d = cnt_q + ONE_LINK;
			state_d = (auto_op_i && transp_flag_i == FLAG_ON) ? ST_TRANS_MASTER
				: ST_PICO_MASTER; // R5 R14
		end else if (cmd_valid_i && !in_transp) begin // R16
			done_d = 1'b1;
			unique case (cmd_i)
				CMD_ESTABLISH, CMD_CONNECT_DEFAULT, CMD_SDAP_CONNECT: begin
					if (master_full || (cmd_i == CMD_SDAP_CONNECT
						&& state_q != ST_SINGLE_SLAVE) || state_q == ST_SCAT_SLAVE) begin
						done_d = 1'b0;
						rej_d = 1'b1;
					end else begin
						cnt_d = cnt_q + ONE_LINK;
						if (state_q == ST_SINGLE_SLAVE) begin
							state_d = ST_SCAT_MASTER; // R11
						end else if (state_q == ST_SCAT_MASTER) begin
							state_d = ST_SCAT_MASTER; // R12
						end else if (cmd_i == CMD_CONNECT_DEFAULT && transp_flag_i == FLAG_ON
							&& cnt_q == NO_LINK) begin
							state_d = ST_TRANS_MASTER; // R14
						end else begin
							state_d = ST_PICO_MASTER; // R5 R7
						end
					end
				end
				CMD_TRANSPARENT: begin
					// Without a single link the UART has no peer to route raw data to
					if (linked_cmd && cnt_q == ONE_LINK) begin // R4 R13
						state_d = (state_q == ST_PICO_MASTER) ? ST_TRANS_MASTER
							: ST_TRANS_SLAVE; // R14
					end else begin
						done_d = 1'b0;
						rej_d = 1'b1;
					end
				end
				default: begin
					done_d = 1'b0;
					rej_d = 1'b1;
				end
			endcase
		end
		// Remote role switches have no input here, so they never move the state // R25
		if (sco_rel_i) begin
			sco_d = 1'b0;
		end else if (sco_req_i && !sco_q && cnt_q != NO_LINK
			&& (state_q == ST_PICO_MASTER || state_q == ST_SINGLE_SLAVE
			|| state_q == ST_SCAT_MASTER)) begin // R9 R20 R22
			sco_d = 1'b1;
			grant_d = 1'b1;
		end
		// A voice link cannot survive the move into scatternet slave
		if (state_d == ST_SCAT_SLAVE) begin // R22
			sco_d = 1'b0;
			grant_d = 1'b0;
		end
		scan_d = (state_d != ST_TRANS_MASTER) && (state_d != ST_TRANS_SLAVE)
			&& (state_d != ST_SCAT_SLAVE); // R1 R16 R20 R22 R12
		transp_d = (state_d == ST_TRANS_MASTER) || (state_d == ST_TRANS_SLAVE); // R13
	end
	// Scan enable and transparent flag registered with the state so they never lag it
	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_IDLE_AUTO;
			cnt_q <= NO_LINK;
			{boot_q, scan_q} <= 2'h3;
			{accept_q, auth_q, ind_q, done_q, rej_q, sco_q, grant_q, transp_q} <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			{boot_q, scan_q, transp_q} <= {boot_d, scan_d, transp_d};
			{accept_q, auth_q, ind_q} <= {accept_d, auth_d, ind_d};
			{done_q, rej_q, sco_q, grant_q} <= {done_d, rej_d, sco_d, grant_d};
		end
	end
	// Poll timer: slot divider then latency count in slots
	logic [31:0] slot_q, slot_d;
	logic [7:0] lat_q, lat_d;
	logic poll_q, poll_d;
	always_comb begin
		slot_d = slot_q + 32'h0000_0001;
		lat_d = lat_q;
		poll_d = 1'b0;
		if (!master_side || cnt_q == NO_LINK) begin
			slot_d = 32'h0000_0000;
			lat_d = 8'h00;
		end else if (slot_q >= 32'(SLOT_CYC - 1)) begin
			slot_d = 32'h0000_0000;
			lat_d = lat_q + 8'h01;
			if (lat_q + 8'h01 >= link_latency_i) begin // R17
				lat_d = 8'h00;
				poll_d = 1'b1;
			end
		end
	end
	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			slot_q <= 32'h0000_0000;
			{lat_q, poll_q} <= 9'h000;
		end else begin
			slot_q <= slot_d;
			{lat_q, poll_q} <= {lat_d, poll_d};
		end
	end
	// Two-entry buffer: output word plus one spare, so a host stall loses nothing
	wlsc_word_s out_q, out_d, spare_q, spare_d, in_word;
	logic out_v_q, out_v_d, spare_v_q, spare_v_d, rdy_q, rdy_d, push, pop;
	always_comb begin
		in_word.raw = in_transp; // R3 R16
		in_word.data = rx_data_i;
		push = rx_valid_i && rdy_q && cnt_q != NO_LINK; // R13
		pop = out_v_q && host_ready_i;
		out_d = out_q;
		out_v_d = out_v_q;
		spare_d = spare_q;
		spare_v_d = spare_v_q;
		if (!out_v_q || pop) begin
			if (spare_v_q) begin
				out_d = spare_q;
				out_v_d = 1'b1;
				spare_d = in_word;
				spare_v_d = push;
			end else begin
				out_d = in_word;
				out_v_d = push;
			end
		end else if (push) begin
			spare_d = in_word;
			spare_v_d = 1'b1;
		end
		rdy_d = !spare_v_d;
	end
	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			{out_q, spare_q} <= '0;
			{out_v_q, spare_v_q, rdy_q} <= 3'h0;
		end else begin
			{out_q, spare_q} <= {out_d, spare_d};
			{out_v_q, spare_v_q, rdy_q} <= {out_v_d, spare_v_d, rdy_d};
		end
	end
	assign {state_o, link_cnt_o, transparent_o, scan_en_o} = {state_q, cnt_q, transp_q, scan_q};
	assign {accept_o, auth_req_o, link_ind_o} = {accept_q, auth_q, ind_q};
	assign {cmd_done_o, cmd_rej_o, poll_o} = {done_q, rej_q, poll_q};
	assign {sco_grant_o, sco_active_o} = {grant_q, sco_q};
	assign {rx_ready_o, host_valid_o, host_word_o} = {rdy_q, out_v_q, out_q};
	sequence s_auto_req;
		state_q == ST_IDLE_AUTO && link_req_i && !boot_q && !uart_break_i && !link_rel_i;
	endsequence
	AST_AUTO_TRANSP: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R1
		(s_auto_req and (force_master_i != FLAG_ON)) |=> accept_o && link_ind_o
		&& state_q == ST_TRANS_SLAVE && !scan_en_o)
		else $error("idle automatic link did not reach transparent slave");
	AST_MANUAL_SLAVE: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R2
		state_q == ST_IDLE_MANUAL && link_req_i && !boot_q && !uart_break_i && !link_rel_i
		&& force_master_i != FLAG_ON |=> state_q == ST_SINGLE_SLAVE && link_ind_o)
		else $error("idle manual link did not reach single slave");
	AST_FORCE_MASTER: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R6
		(s_auto_req and (force_master_i == FLAG_ON)) |=> state_q == ST_PICO_MASTER)
		else $error("forced master link not in piconet master");
	AST_SCAT_REFUSE: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R12
		state_q == ST_SCAT_MASTER && link_req_i |=> !accept_o)
		else $error("scatternet master accepted a link");
	AST_MAX_LINKS: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R8
		cnt_q <= 4'(MAX_LINKS))
		else $error("link count above maximum");
	AST_TRANSP_ONE: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R13
		$rose(transparent_o) |-> cnt_q == ONE_LINK)
		else $error("transparent mode without exactly one link");
	AST_BREAK_MASTER: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R15
		state_q == ST_TRANS_MASTER && uart_break_i && !boot_q
		|=> state_q == ST_PICO_MASTER && scan_en_o)
		else $error("break did not return to piconet master");
	AST_BREAK_SLAVE: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R24
		state_q == ST_TRANS_SLAVE && uart_break_i && !boot_q |=> state_q == ST_SINGLE_SLAVE)
		else $error("break did not return to single slave");
	AST_TRANSP_QUIET: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R16
		transparent_o && cmd_valid_i |=> !cmd_done_o && !cmd_rej_o && !link_ind_o)
		else $error("transparent state answered a command");
	AST_SCAT_SLAVE_SCO: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R22
		state_q == ST_SCAT_SLAVE |=> !sco_grant_o)
		else $error("voice link granted in scatternet slave");
	AST_LAST_RELEASE: assert property (@(posedge clock_i) disable iff (!rst_sync_q) // R23
		cnt_q == ONE_LINK && link_rel_i && !boot_q && !(uart_break_i && transparent_o)
		|=> cnt_q == NO_LINK && (state_q == ST_IDLE_AUTO || state_q == ST_IDLE_MANUAL))
		else $error("last release did not return to idle");

endmodule // wlsc_ctrl

// File: src/wlsc_pkg.sv
// Package with states, commands, constants and carriers of the link state controller
package wlsc_pkg;

	typedef enum logic [7:0] {
		ST_IDLE_AUTO = 8'h01,
		ST_IDLE_MANUAL = 8'h02,
		ST_PICO_MASTER = 8'h04,
		ST_SCAT_MASTER = 8'h08,
		ST_TRANS_MASTER = 8'h10,
		ST_SINGLE_SLAVE = 8'h20,
		ST_SCAT_SLAVE = 8'h40,
		ST_TRANS_SLAVE = 8'h80
	} wlsc_state_e;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_ESTABLISH = 3'h1,
		CMD_CONNECT_DEFAULT = 3'h2,
		CMD_SDAP_CONNECT = 3'h3,
		CMD_TRANSPARENT = 3'h4
	} wlsc_cmd_e;

	// Payload word toward the host; raw set means transparent stream, not an event
	typedef struct packed {
		logic raw;
		logic [7:0] data;
	} wlsc_word_s;

	localparam logic [7:0] FLAG_ON = 8'h01;
	localparam logic [7:0] FLAG_OFF = 8'h00;
	localparam logic [3:0] ONE_LINK = 4'h1;
	localparam logic [3:0] NO_LINK = 4'h0;
	localparam logic [7:0] LATENCY_DEFAULT = 8'h28;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLOT_TIME_NS = 625000;

endpackage
